/* include/dswf_map.svh */
// Constants of the serial write front end of the 12-bit converter.
// Summary of operation
// - One 12-bit conversion code sets the output level; writes load it together with the two mode bits.
// - Data line is shifted into a 16-bit register on each serial clock fall of an open frame.
// - Low frame strobe marks a frame; bits are accepted only while it is low.
// - On the 16th falling edge with strobe low, code and mode are applied.
// - Strobe rising before the 16th edge aborts; code and mode stay unchanged.
// - After power-on the output is zero until the first valid frame applies.
// - Power-down entry happens only through write frames; exit through a write frame or a reset.
// - Frame is MSB first: two ignored bits, two mode bits, twelve code bits.
// - An aborted frame clears the input shift register.
`ifndef DSWF_MAP_SVH
`define DSWF_MAP_SVH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define DSWF_FRAME_BITS      16
`define DSWF_CODE_BITS       12
`define DSWF_CODE_LSB        0
`define DSWF_MODE_LO_POS     12
`define DSWF_MODE_HI_POS     13

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DSWF_CODE_RESET      12'h000
`define DSWF_MODE_RESET      2'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DSWF_CLK_PERIOD_NS   20
`define DSWF_STROBE_HIGH_NS  33
`define DSWF_STROBE_HIGH_CYC ((`DSWF_STROBE_HIGH_NS+`DSWF_CLK_PERIOD_NS-1)/`DSWF_CLK_PERIOD_NS)

`endif

/* include/dswf_pkg.sv */
// Types of the serial write front end of the 12-bit converter.
package dswf_pkg;

   // -------------------------------------------------------------------------
   // Frame receiver states
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      st_idle,
      st_shift,
      st_hold
   } dswf_state_t;

   // -------------------------------------------------------------------------
   // Operating modes, in the order of the two mode bits
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      mode_normal,
      mode_pd_1k,
      mode_pd_100k,
      mode_hiz
   } dswf_mode_t;

endpackage : dswf_pkg

/* verilog/dswf_write_frontend.sv */
// Serial write front end: frame receiver, code and power-mode registers.
`timescale 1ns/100ps
`include "dswf_map.svh"

module dswf_write_frontend #(
   parameter int FRAME_W     = `DSWF_FRAME_BITS,
   parameter int CODE_W      = `DSWF_CODE_BITS,
   parameter int HIGH_MIN_CY = `DSWF_STROBE_HIGH_CYC
) (
   // System clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // Serial write interface
   input  wire logic              frame_n_i,
   input  wire logic              sclk_i,
   input  wire logic              din_i,
   // Converter code and mode
   output logic [CODE_W-1:0]      code_o,
   output logic                   power_mode_bit_hi_o,
   output logic                   power_mode_bit_lo_o,
   output logic                   written_o,
   // Output stage controls
   output logic                   amp_on_o,
   output logic                   load_1k_o,
   output logic                   load_100k_o,
   output logic                   out_hiz_o,
   // Frame events and status
   output logic                   frame_busy_o,
   output logic                   apply_o,
   output logic                   abort_o
);

   // -------------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------------
   localparam int CNT_W = $clog2(FRAME_W + 1);

   if (FRAME_W != CODE_W + 4)
   begin : g_bad_frame_w
      $error("Frame width must be the code width plus four.");
   end
   if (HIGH_MIN_CY < 1 || HIGH_MIN_CY > 255)
   begin : g_bad_high_min
      $error("Least strobe high time must be 1 to 255 cycles.");
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   dswf_pkg::dswf_state_t state_r;
   dswf_pkg::dswf_state_t state_nxt;
   dswf_pkg::dswf_mode_t  mode_r;
   dswf_pkg::dswf_mode_t  mode_nxt;
   logic [FRAME_W-1:0]    shift_r;
   logic [FRAME_W-1:0]    shift_nxt;
   logic [CNT_W-1:0]      count_r;
   logic [CNT_W-1:0]      count_nxt;
   logic [7:0]            high_cnt_r;
   logic [7:0]            high_cnt_nxt;
   logic [CODE_W-1:0]     code_r;
   logic [CODE_W-1:0]     code_nxt;
   logic                  sclk_prev_r;
   logic                  strobe_prev_r;
   logic                  written_r;
   logic                  apply_r;
   logic                  abort_r;
   logic                  busy_r;
   logic                  amp_on_r;
   logic                  load_1k_r;
   logic                  load_100k_r;
   logic                  hiz_r;

   // -------------------------------------------------------------------------
   // Edge detection and decoding
   // -------------------------------------------------------------------------
   wire                   sclk_fall;
   wire                   strobe_fall;
   wire                   strobe_high;
   wire                   high_long;
   wire                   last_bit;
   wire [FRAME_W-1:0]     shifted;
   wire                   do_start;
   wire                   do_shift;
   wire                   do_apply;
   wire                   do_abort;

   assign sclk_fall   = sclk_prev_r & ~sclk_i;
   assign strobe_high = frame_n_i;
   assign strobe_fall = strobe_prev_r & ~frame_n_i;
   assign high_long   = (high_cnt_r >= 8'(HIGH_MIN_CY));
   assign last_bit    = (count_r == CNT_W'(FRAME_W - 1));
   assign shifted     = {shift_r[FRAME_W-2:0], din_i};

   // A frame opens only on a strobe fall after a long enough high time.
   assign do_start = (state_r == dswf_pkg::st_idle) & strobe_fall & high_long;
   // Bits are accepted only while the strobe stays low in an open frame.
   assign do_shift = (state_r == dswf_pkg::st_shift) & ~strobe_high & sclk_fall;
   assign do_apply = do_shift & last_bit;
   // A strobe rise before the last edge abandons the frame.
   assign do_abort = (state_r == dswf_pkg::st_shift) & strobe_high;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      count_nxt = count_r;
      case (state_r)
         dswf_pkg::st_idle:
         begin
            if (do_start)
            begin
               state_nxt = dswf_pkg::st_shift;
               shift_nxt = '0;
               count_nxt = '0;
            end
         end
         dswf_pkg::st_shift:
         begin
            if (do_abort)
            begin
               state_nxt = dswf_pkg::st_idle;
               shift_nxt = '0;
               count_nxt = '0;
            end
            else if (do_apply)
            begin
               state_nxt = dswf_pkg::st_hold;
               shift_nxt = shifted;
               count_nxt = '0;
            end
            else if (do_shift)
            begin
               shift_nxt = shifted;
               count_nxt = count_r + CNT_W'(1);
            end
         end
         dswf_pkg::st_hold:
         begin
            // Clock falls are ignored here until the strobe goes high.
            if (strobe_high)
            begin
               state_nxt = dswf_pkg::st_idle;
            end
         end
         default:
         begin
            state_nxt = dswf_pkg::st_idle;
            shift_nxt = '0;
            count_nxt = '0;
         end
      endcase
   end

   // -------------------------------------------------------------------------
   // Code and mode update
   // -------------------------------------------------------------------------
   // Only a complete frame changes the code or the mode.
   assign code_nxt = do_apply ? shifted[`DSWF_CODE_LSB +: CODE_W] : code_r;
   assign mode_nxt = do_apply
                     ? dswf_pkg::dswf_mode_t'({shifted[`DSWF_MODE_HI_POS],
                                               shifted[`DSWF_MODE_LO_POS]})
                     : mode_r;

   // Strobe high time counts up while high and saturates.
   assign high_cnt_nxt = !strobe_high ? 8'h00
                         : (high_long ? high_cnt_r : high_cnt_r + 8'h01);

   // -------------------------------------------------------------------------
   // Receiver registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r       <= dswf_pkg::st_idle;
         shift_r       <= '0;
         count_r       <= '0;
         sclk_prev_r   <= 1'b0;
         strobe_prev_r <= 1'b0;
         high_cnt_r    <= 8'h00;
      end
      else
      begin
         state_r       <= state_nxt;
         shift_r       <= shift_nxt;
         count_r       <= count_nxt;
         sclk_prev_r   <= sclk_i;
         strobe_prev_r <= frame_n_i;
         high_cnt_r    <= high_cnt_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Code, mode and output stage registers
   // -------------------------------------------------------------------------
   // Reset leaves code zero in normal mode, so the output sits at zero.
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         code_r    <= `DSWF_CODE_RESET;
         mode_r    <= dswf_pkg::dswf_mode_t'(`DSWF_MODE_RESET);
         written_r <= 1'b0;
      end
      else
      begin
         code_r    <= code_nxt;
         mode_r    <= mode_nxt;
         written_r <= written_r | do_apply;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         amp_on_r    <= 1'b1;
         load_1k_r   <= 1'b0;
         load_100k_r <= 1'b0;
         hiz_r       <= 1'b0;
      end
      else
      begin
         amp_on_r    <= (mode_nxt == dswf_pkg::mode_normal);
         load_1k_r   <= (mode_nxt == dswf_pkg::mode_pd_1k);
         load_100k_r <= (mode_nxt == dswf_pkg::mode_pd_100k);
         hiz_r       <= (mode_nxt == dswf_pkg::mode_hiz);
      end
   end

   // -------------------------------------------------------------------------
   // Event and status registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         apply_r <= 1'b0;
         abort_r <= 1'b0;
         busy_r  <= 1'b0;
      end
      else
      begin
         apply_r <= do_apply;
         abort_r <= do_abort;
         busy_r  <= (state_nxt == dswf_pkg::st_shift);
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign code_o              = code_r;
   assign power_mode_bit_hi_o = mode_r[1];
   assign power_mode_bit_lo_o = mode_r[0];
   assign written_o           = written_r;
   assign amp_on_o            = amp_on_r;
   assign load_1k_o           = load_1k_r;
   assign load_100k_o         = load_100k_r;
   assign out_hiz_o           = hiz_r;
   assign frame_busy_o        = busy_r;
   assign apply_o             = apply_r;
   assign abort_o             = abort_r;

endmodule : dswf_write_frontend

/* verification/dswf_write_frontend_monitor.sv */
// Checker of the serial write front end outputs.
`timescale 1ns/100ps
module dswf_write_frontend_monitor #(
   parameter int CODE_W = 12
) (
   // Clock and reset
   input wire logic              clk_sys_i,
   input wire logic              rst_i,
   // Serial strobe
   input wire logic              frame_n_i,
   // Code and mode
   input wire logic [CODE_W-1:0] code_o,
   input wire logic              power_mode_bit_hi_o,
   input wire logic              power_mode_bit_lo_o,
   input wire logic              written_o,
   // Output stage
   input wire logic              amp_on_o,
   input wire logic              load_1k_o,
   input wire logic              load_100k_o,
   input wire logic              out_hiz_o,
   // Frame events
   input wire logic              frame_busy_o,
   input wire logic              apply_o,
   input wire logic              abort_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   apply_one_cycle_a: assert property (apply_o |=> !apply_o)
      else $error("apply pulse too long");
   abort_one_cycle_a: assert property (abort_o |=> !abort_o)
      else $error("abort pulse too long");
   code_hold_a: assert property (!apply_o |-> $stable(code_o))
      else $error("code changed without apply");
   mode_hold_a: assert property (!apply_o |->
      $stable({power_mode_bit_hi_o, power_mode_bit_lo_o})) else $error("mode changed without apply");
   stage_decode_a: assert property ({out_hiz_o, load_100k_o, load_1k_o, amp_on_o} ==
      (4'h1 << {power_mode_bit_hi_o, power_mode_bit_lo_o})) else $error("stage decode wrong");
   written_sticky_a: assert property (written_o |=> written_o)
      else $error("written flag dropped");
   zero_until_write_a: assert property (!written_o |-> code_o == '0 && amp_on_o)
      else $error("output not zero before first write");
   apply_in_frame_a: assert property (apply_o |-> $past(frame_busy_o) && !$past(frame_n_i))
      else $error("apply outside open frame");
   abort_cause_a: assert property (abort_o |-> $past(frame_n_i) && $past(frame_busy_o))
      else $error("abort without strobe rise");
   busy_strobe_a: assert property (frame_busy_o |-> !$past(frame_n_i))
      else $error("busy with strobe high");
endmodule : dswf_write_frontend_monitor
bind dswf_write_frontend dswf_write_frontend_monitor #(.CODE_W(CODE_W)) dswf_mon_inst (
   .clk_sys_i, .rst_i, .frame_n_i, .code_o, .power_mode_bit_hi_o, .power_mode_bit_lo_o,
   .written_o, .amp_on_o, .load_1k_o, .load_100k_o, .out_hiz_o, .frame_busy_o, .apply_o,
   .abort_o);

/* verification/dswf_host_model.sv */
// Serial host model that drives write frames into the front end.
`timescale 1ns/100ps
module dswf_host_model (
   // Clock
   input  wire logic clk_sys_i,
   // Serial link
   output logic      frame_n_o,
   output logic      sclk_o,
   output logic      din_o
);
   initial
   begin
      frame_n_o = 1'b1;
      sclk_o    = 1'b0;
      din_o     = 1'b0;
   end
   // Gives n serial clock falls, most significant bit first.
   task automatic clocks(input logic [15:0] w, input int n, input int slow);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_sys_i);
         #1;
         sclk_o = 1'b1;
         din_o  = w[15-i];
         repeat (slow) @(posedge clk_sys_i);
         @(posedge clk_sys_i);
         #1;
         sclk_o = 1'b0;
         repeat (slow) @(posedge clk_sys_i);
      end
   endtask : clocks
   // Opens a frame with a strobe fall, shifts n bits, then ends it unless stay_low is set.
   task automatic send(input logic [15:0] w, input int n, input int slow, input bit stay_low);
      @(posedge clk_sys_i);
      #1;
      frame_n_o = 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1;
      frame_n_o = 1'b0;
      clocks(w, n, slow);
      @(posedge clk_sys_i);
      #1;
      din_o = ~din_o;
      if (!stay_low)
      begin
         frame_n_o = 1'b1;
      end
   endtask : send
endmodule : dswf_host_model

/* verification/tb_dswf_write_frontend.sv */
// Testbench of the serial write front end.
`timescale 1ns/100ps
module tb_dswf_write_frontend;
   logic        clk_sys_i = 1'b0;
   logic        rst_i     = 1'b1;
   logic        frame_n_i, sclk_i, din_i;
   logic [11:0] code_o;
   logic        power_mode_bit_hi_o, power_mode_bit_lo_o, written_o, amp_on_o;
   logic        load_1k_o, load_100k_o, out_hiz_o, frame_busy_o, apply_o, abort_o;
   int          n_errors = 0, n_tests = 0, n_apply = 0, n_abort = 0, n_cyc = 0;
   int          ea = 0, eb = 0;
   logic [11:0] lc = 12'h000;
   logic [1:0]  lm = 2'h0;
   always #10 clk_sys_i = ~clk_sys_i;
   dswf_write_frontend dswf_write_frontend_inst (.clk_sys_i, .rst_i, .frame_n_i, .sclk_i,
      .din_i, .code_o, .power_mode_bit_hi_o, .power_mode_bit_lo_o, .written_o, .amp_on_o,
      .load_1k_o, .load_100k_o, .out_hiz_o, .frame_busy_o, .apply_o, .abort_o);
   dswf_host_model dswf_host_model_inst (.clk_sys_i, .frame_n_o(frame_n_i), .sclk_o(sclk_i),
      .din_o(din_i));
   always @(posedge clk_sys_i)
   begin
      n_cyc++;
      n_apply += (apply_o === 1'b1);
      n_abort += (abort_o === 1'b1);
      if (n_cyc == 20000)
      begin
         n_errors++;
         complete_run();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic expect_state(input logic w);
      repeat (2) @(posedge clk_sys_i);
      #1;
      check(16'(code_o), 16'(lc), "code");
      check(16'({power_mode_bit_hi_o, power_mode_bit_lo_o}), 16'(lm), "mode");
      check(16'({out_hiz_o, load_100k_o, load_1k_o, amp_on_o}), 16'h1 << lm, "stage");
      check(16'(written_o), 16'(w), "written");
      check(16'(n_apply), 16'(ea), "apply count");
      check(16'(n_abort), 16'(eb), "abort count");
      check(16'(frame_busy_o), 16'h0000, "busy");
   endtask : expect_state
   task automatic frame(input logic [1:0] m, input logic [11:0] c, input int slow);
      dswf_host_model_inst.send({2'b11, m, c}, 16, slow, 1'b0);
      ea++;
      lc = c;
      lm = m;
      expect_state(1'b1);
   endtask : frame
   task automatic t_modes();
      for (int m = 0; m < 4; m++)
      begin
         frame(2'(m), 12'hA5C ^ 12'(m), (m == 3) ? 2 : 0);
      end
      $display("test modes done");
   endtask : t_modes
   task automatic t_idle();
      dswf_host_model_inst.clocks(16'h0FFF, 16, 0);
      expect_state(1'b1);
      $display("test idle clocks done");
   endtask : t_idle
   task automatic t_abort();
      dswf_host_model_inst.send(16'h3123, 15, 0, 1'b0);
      check(16'(frame_busy_o), 16'h0001, "busy in frame");
      eb++;
      expect_state(1'b1);
      frame(2'h0, 12'h0BC, 0);
      $display("test abort done");
   endtask : t_abort
   task automatic t_hold();
      dswf_host_model_inst.send(16'h13C3, 16, 0, 1'b1);
      ea++;
      lc = 12'h3C3;
      lm = 2'h1;
      dswf_host_model_inst.clocks(16'hFFFF, 16, 0);
      expect_state(1'b1);
      frame(2'h0, 12'h800, 1);
      $display("test held strobe done");
   endtask : t_hold
   task automatic t_reset();
      repeat (20) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      expect_state(1'b0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_rst2();
      #1;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      lc = 12'h000;
      lm = 2'h0;
      expect_state(1'b0);
      frame(2'h2, 12'hFFF, 0);
      $display("test second reset done");
   endtask : t_rst2
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   initial
   begin
      t_reset();
      t_modes();
      t_idle();
      t_abort();
      t_hold();
      t_rst2();
      complete_run();
   end
endmodule : tb_dswf_write_frontend
